// ---- logic/epoch_sync_pkg.sv ----
// constants, register map and carrier types for the epoch sync and code start block
package epoch_sync_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam longint SECOND_PERIOD_NS = 1000000000;
  localparam int SECOND_CYCLES = int'(SECOND_PERIOD_NS / CLK_PERIOD_NS);
  localparam int EPOCH_PERIOD_NS = 1000000;
  localparam int EPOCH_CYCLES = EPOCH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NUM_GEN = 3;

  localparam logic [5:0] OFS_SYNC_CONFIG = 6'h00;
  localparam logic [5:0] OFS_TIME_LOW = 6'h04;
  localparam logic [5:0] OFS_TIME_HIGH = 6'h08;
  localparam logic [5:0] OFS_CODE_GEN_CTRL = 6'h0C;
  localparam logic [5:0] OFS_CORR_CTRL = 6'h10;
  localparam logic [5:0] OFS_OSC_SETTINGS = 6'h14;
  localparam logic [5:0] OFS_SLEW_AMOUNT = 6'h18;
  localparam logic [5:0] OFS_INTEG_PERIOD = 6'h1C;
  localparam logic [5:0] OFS_CODE_LENGTH = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;

  localparam int EXT_SECOND_BIT = 0;
  localparam int EXT_EPOCH_BIT = 1;
  localparam int LAUNCH_LSB = 0;
  localparam int TRIGGER_BIT = 3;
  localparam int ALIGN_BIT = 0;
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_RUNNING_BIT = 1;
  localparam int ST_ARMED_LSB = 2;

  localparam logic [31:0] RST_RATE = 32'h0100_0000;
  localparam logic [31:0] RST_INTEG_PERIOD = 32'h0000_C350;
  localparam logic [31:0] RST_CODE_LENGTH = 32'h0000_03FF;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } bus_req_type;

  typedef enum {code_idle, code_running} code_state_type;
endpackage : epoch_sync_pkg

// ---- logic/gnss_epoch_sync_code_start.sv ----
// epoch selection, deferred time counter load and code generator start logic
`timescale 1ns/100ps
`default_nettype none
module gnss_epoch_sync_code_start #(
  parameter int SECOND_CYCLES_P = epoch_sync_pkg::SECOND_CYCLES,
  parameter int EPOCH_CYCLES_P = epoch_sync_pkg::EPOCH_CYCLES
) (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // synchronous reset
  input wire epoch_sync_pkg::bus_req_type bus_req, // avalon request
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  input wire logic second_pulse_input, // pin from second pulse master
  input wire logic epoch_sync_input, // pin from epoch master
  output logic second_pulse_output, // internal second pulse to pin
  output logic epoch_sync_output, // internal epoch to pin
  output logic second_pulse, // selected second pulse event
  output logic sync_epoch_pulse, // selected sync epoch event
  output logic integration_epoch, // integration epoch event
  output logic [2:0] code_start, // generator start events
  output logic chip_edge, // code oscillator chip edge
  output logic code_epoch, // code epoch event
  output logic [63:0] time_count // internal time counter
);
  import epoch_sync_pkg::*;

  function automatic logic word_hit(input logic [5:0] a, input logic [5:0] o);
    word_hit = (a[5:2] == o[5:2]);
  endfunction : word_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // pin synchroniser, three stages
  logic [1:0] pin_ff1, pin_ff2, pin_ff3, pin_lvl, next_pin_lvl, pin_rise;
  always_comb begin
    next_pin_lvl = (pin_ff2 & pin_ff3) | (pin_lvl & (pin_ff2 | pin_ff3));
    pin_rise = pin_ff2 & pin_ff3 & ~pin_lvl;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_ff1 <= 2'h0;
      pin_ff2 <= 2'h0;
      pin_ff3 <= 2'h0;
      pin_lvl <= 2'h0;
    end else begin
      pin_ff1 <= {epoch_sync_input, second_pulse_input};
      pin_ff2 <= pin_ff1;
      pin_ff3 <= pin_ff2;
      pin_lvl <= next_pin_lvl;
    end
  end

  logic ext_second, ext_epoch, next_ext_second, next_ext_epoch;
  logic [63:0] staged, next_staged, next_time_count;
  logic load_pending, next_load_pending;
  logic [2:0] armed, next_armed, fire;
  logic trigger_sync, next_trigger_sync, align, next_align;
  logic [31:0] rate, next_rate, integ_period, next_integ_period, code_length, next_code_length;
  logic [31:0] sec_cnt, next_sec_cnt, ep_cnt, next_ep_cnt, integ_cnt, next_integ_cnt;
  logic [31:0] phase, next_phase, chip_cnt, next_chip_cnt;
  logic [33:0] phase_sum;
  code_state_type code_state, next_code_state;
  logic [31:0] next_readdata, rd_value, wd;
  logic next_waitrequest, acc_wr, slew_wr, int_second, int_epoch, integ_wrap, code_wrap, trig_evt, realign;
  logic next_second_output, next_epoch_output, next_second, next_sync_epoch, next_integ, next_chip, next_code_epoch;

  always_comb begin
    wd = bus_req.writedata;
    acc_wr = bus_req.write && !waitrequest;
    slew_wr = acc_wr && word_hit(bus_req.address, OFS_SLEW_AMOUNT);
    next_waitrequest = !((bus_req.read || bus_req.write) && waitrequest);
    rd_value = 32'h0000_0000;
    if (word_hit(bus_req.address, OFS_SYNC_CONFIG)) begin
      rd_value[EXT_SECOND_BIT] = ext_second;
      rd_value[EXT_EPOCH_BIT] = ext_epoch;
    end else if (word_hit(bus_req.address, OFS_TIME_LOW)) begin
      rd_value = time_count[31:0];
    end else if (word_hit(bus_req.address, OFS_TIME_HIGH)) begin
      rd_value = time_count[63:32];
    end else if (word_hit(bus_req.address, OFS_CODE_GEN_CTRL)) begin
      rd_value[LAUNCH_LSB +: NUM_GEN] = armed;
      rd_value[TRIGGER_BIT] = trigger_sync;
    end else if (word_hit(bus_req.address, OFS_CORR_CTRL)) begin
      rd_value[ALIGN_BIT] = align;
    end else if (word_hit(bus_req.address, OFS_OSC_SETTINGS)) begin
      rd_value = rate;
    end else if (word_hit(bus_req.address, OFS_INTEG_PERIOD)) begin
      rd_value = integ_period;
    end else if (word_hit(bus_req.address, OFS_CODE_LENGTH)) begin
      rd_value = code_length;
    end else if (word_hit(bus_req.address, OFS_STATUS)) begin
      rd_value[ST_PENDING_BIT] = load_pending;
      rd_value[ST_RUNNING_BIT] = (code_state == code_running);
      rd_value[ST_ARMED_LSB +: NUM_GEN] = armed;
    end
    next_readdata = (bus_req.read && waitrequest) ? rd_value : readdata;

    next_ext_second = ext_second;
    next_ext_epoch = ext_epoch;
    next_trigger_sync = trigger_sync;
    next_align = align;
    next_rate = rate;
    next_integ_period = integ_period;
    next_code_length = code_length;
    next_staged = staged;

    // internal dividers
    int_second = (sec_cnt == 32'(SECOND_CYCLES_P - 1));
    int_epoch = (ep_cnt == 32'(EPOCH_CYCLES_P - 1));
    next_sec_cnt = int_second ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
    next_ep_cnt = int_epoch ? 32'h0000_0000 : ep_cnt + 32'h0000_0001;
    next_second_output = int_second;
    next_epoch_output = int_epoch;
    next_second = ext_second ? pin_rise[0] : int_second;
    next_sync_epoch = ext_epoch ? pin_rise[1] : int_epoch;

    // time counter, deferred load
    if (load_pending && sync_epoch_pulse) begin
      next_time_count = staged;
    end else begin
      next_time_count = time_count + 64'h0000_0000_0000_0001;
    end
    next_load_pending = load_pending && !sync_epoch_pulse;

    // code oscillator and chip counter
    phase_sum = {2'h0, phase} + {2'h0, rate} + (slew_wr ? {2'h0, wd} : 34'h0_0000_0000);
    next_phase = phase_sum[31:0];
    next_chip = |phase_sum[33:32];
    code_wrap = next_chip && (chip_cnt == code_length - 32'h0000_0001);
    next_code_epoch = code_wrap;

    // generator start
    trig_evt = trigger_sync ? sync_epoch_pulse : integration_epoch;
    fire = armed & {NUM_GEN{trig_evt}};
    next_armed = armed & ~fire;
    next_code_state = code_state;
    if (|fire) begin
      next_chip_cnt = 32'h0000_0000;
      next_code_state = code_running;
      next_code_epoch = 1'b0;
    end else if (next_chip) begin
      next_chip_cnt = code_wrap ? 32'h0000_0000 : chip_cnt + 32'h0000_0001;
    end else begin
      next_chip_cnt = chip_cnt;
    end

    // integration epoch, optionally realigned to the code epoch
    realign = align && (code_state == code_running) && code_epoch;
    integ_wrap = (integ_cnt == integ_period - 32'h0000_0001);
    next_integ = integ_wrap || realign;
    next_integ_cnt = next_integ ? 32'h0000_0000 : integ_cnt + 32'h0000_0001;

    if (acc_wr) begin
      case (1'b1)
        word_hit(bus_req.address, OFS_SYNC_CONFIG): begin
          if (bus_req.byteenable[0]) begin
            next_ext_second = wd[EXT_SECOND_BIT];
            next_ext_epoch = wd[EXT_EPOCH_BIT];
          end
        end
        word_hit(bus_req.address, OFS_TIME_LOW): begin
          next_staged[31:0] = merge(staged[31:0], wd, bus_req.byteenable);
          next_load_pending = 1'b1;
        end
        word_hit(bus_req.address, OFS_TIME_HIGH): begin
          next_staged[63:32] = merge(staged[63:32], wd, bus_req.byteenable);
          next_load_pending = 1'b1;
        end
        word_hit(bus_req.address, OFS_CODE_GEN_CTRL): begin
          if (bus_req.byteenable[0]) begin
            next_armed = next_armed | wd[LAUNCH_LSB +: NUM_GEN];
            next_trigger_sync = wd[TRIGGER_BIT];
          end
        end
        word_hit(bus_req.address, OFS_CORR_CTRL): begin
          if (bus_req.byteenable[0]) begin
            next_align = wd[ALIGN_BIT];
          end
        end
        word_hit(bus_req.address, OFS_OSC_SETTINGS): begin
          next_rate = merge(rate, wd, bus_req.byteenable);
        end
        word_hit(bus_req.address, OFS_INTEG_PERIOD): begin
          next_integ_period = merge(integ_period, wd, bus_req.byteenable);
        end
        word_hit(bus_req.address, OFS_CODE_LENGTH): begin
          next_code_length = merge(code_length, wd, bus_req.byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
      ext_second <= 1'b0;
      ext_epoch <= 1'b0;
      staged <= 64'h0000_0000_0000_0000;
      load_pending <= 1'b0;
      time_count <= 64'h0000_0000_0000_0000;
      armed <= 3'h0;
      trigger_sync <= 1'b0;
      align <= 1'b0;
      rate <= RST_RATE;
      integ_period <= RST_INTEG_PERIOD;
      code_length <= RST_CODE_LENGTH;
      sec_cnt <= 32'h0000_0000;
      ep_cnt <= 32'h0000_0000;
      integ_cnt <= 32'h0000_0000;
      phase <= 32'h0000_0000;
      chip_cnt <= 32'h0000_0000;
      code_state <= code_idle;
      second_pulse_output <= 1'b0;
      epoch_sync_output <= 1'b0;
      second_pulse <= 1'b0;
      sync_epoch_pulse <= 1'b0;
      integration_epoch <= 1'b0;
      code_start <= 3'h0;
      chip_edge <= 1'b0;
      code_epoch <= 1'b0;
    end else begin
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      ext_second <= next_ext_second;
      ext_epoch <= next_ext_epoch;
      staged <= next_staged;
      load_pending <= next_load_pending;
      time_count <= next_time_count;
      armed <= next_armed;
      trigger_sync <= next_trigger_sync;
      align <= next_align;
      rate <= next_rate;
      integ_period <= next_integ_period;
      code_length <= next_code_length;
      sec_cnt <= next_sec_cnt;
      ep_cnt <= next_ep_cnt;
      integ_cnt <= next_integ_cnt;
      phase <= next_phase;
      chip_cnt <= next_chip_cnt;
      code_state <= next_code_state;
      second_pulse_output <= next_second_output;
      epoch_sync_output <= next_epoch_output;
      second_pulse <= next_second;
      sync_epoch_pulse <= next_sync_epoch;
      integration_epoch <= next_integ;
      code_start <= fire;
      chip_edge <= next_chip;
      code_epoch <= next_code_epoch;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_time_write;
    acc_wr && (word_hit(bus_req.address, OFS_TIME_LOW) || word_hit(bus_req.address, OFS_TIME_HIGH));
  endsequence
  sequence s_epoch_load;
    load_pending && sync_epoch_pulse;
  endsequence
  sequence s_pin_event;
    pin_rise[0] ##1 !pin_rise[0];
  endsequence

  chk_bus_answer: assert property ((bus_req.read || bus_req.write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle wide");
  chk_second_select: assert property (ext_second && pin_rise[0] |=> second_pulse)
    else $error("external second pulse not forwarded");
  chk_second_internal: assert property (!ext_second && int_second |=> second_pulse && second_pulse_output)
    else $error("internal second pulse not forwarded");
  chk_epoch_select: assert property (ext_epoch |=> sync_epoch_pulse == $past(pin_rise[1]))
    else $error("sync epoch does not follow external pin");
  chk_load_deferred: assert property (s_time_write |=> load_pending)
    else $error("time counter write not staged");
  chk_load_at_epoch: assert property (s_epoch_load |=> time_count == $past(staged))
    else $error("staged time not loaded at sync epoch");
  chk_launch_fire: assert property (armed[0] && trig_evt |=> code_start[0] ##1 !code_start[0])
    else $error("armed generator did not start once");
  chk_phase_kept: assert property ((|fire) && !slew_wr |=> phase == $past(phase) + $past(rate))
    else $error("code phase disturbed by start");
  chk_align_restart: assert property (realign |=> integration_epoch ##1 !integration_epoch)
    else $error("integration epoch not realigned to code epoch");
  chk_single_event: assert property (pin_rise[0] |-> s_pin_event)
    else $error("one input pulse gave more than one event");
endmodule : gnss_epoch_sync_code_start
`default_nettype wire

// ---- tb/epoch_master_model.sv ----
// partner model: master receiver chip driving the shared pulse pins
`timescale 1ns/100ps
`default_nettype none
module epoch_master_model (
  input wire logic ref_clk, // shared core clock
  input wire logic fire_second, // request one second pulse
  input wire logic fire_epoch, // request one epoch pulse
  output logic second_pin, // to second_pulse_input
  output logic epoch_pin // to epoch_sync_input
);
  logic [2:0] sec_left = 3'h0;
  logic [2:0] ep_left = 3'h0;
  // each pulse stands four cycles, pins idle low
  always_ff @(posedge ref_clk) begin
    sec_left <= fire_second ? 3'h4 : (sec_left != 3'h0 ? sec_left - 3'h1 : 3'h0);
    ep_left <= fire_epoch ? 3'h4 : (ep_left != 3'h0 ? ep_left - 3'h1 : 3'h0);
  end
  assign second_pin = sec_left != 3'h0;
  assign epoch_pin = ep_left != 3'h0;
endmodule : epoch_master_model
`default_nettype wire

// ---- tb/gnss_epoch_sync_code_start_tb.sv ----
// self-checking bench for epoch selection, time load and code start
`timescale 1ns/100ps
`default_nettype none
module gnss_epoch_sync_code_start_tb;
  import epoch_sync_pkg::*;
  localparam int TIMEOUT_CYCLES = 64000;
  localparam int SECOND_P = 40;
  localparam int EPOCH_P = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_type bus_req = '0;
  logic fire_second = 1'b0;
  logic fire_epoch = 1'b0;
  logic second_pin, epoch_pin, waitrequest, second_pulse_output, epoch_sync_output;
  logic second_pulse, sync_epoch_pulse, integration_epoch, chip_edge, code_epoch;
  logic [31:0] readdata;
  logic [2:0] code_start;
  logic [63:0] time_count;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  epoch_master_model master_u (.ref_clk(ref_clk), .fire_second(fire_second), .fire_epoch(fire_epoch),
    .second_pin(second_pin), .epoch_pin(epoch_pin));

  gnss_epoch_sync_code_start #(.SECOND_CYCLES_P(SECOND_P), .EPOCH_CYCLES_P(EPOCH_P)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest),
    .second_pulse_input(second_pin), .epoch_sync_input(epoch_pin), .second_pulse_output(second_pulse_output),
    .epoch_sync_output(epoch_sync_output), .second_pulse(second_pulse), .sync_epoch_pulse(sync_epoch_pulse),
    .integration_epoch(integration_epoch), .code_start(code_start), .chip_edge(chip_edge),
    .code_epoch(code_epoch), .time_count(time_count));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYCLES) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      give_verdict();
    end
  end

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check_val

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
    output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge ref_clk);
    bus_req <= '{read: !wr, write: wr, address: addr, byteenable: 4'hF, writedata: wdata};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0);
    rdata = readdata;
    bus_req <= '0;
    check_val(64'(n), 64'h2, "bus answer");
  endtask : bus_xfer

  task automatic reg_wr(input logic [5:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, wdata, dummy);
  endtask : reg_wr

  task automatic reg_chk(input logic [5:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(1'b0, addr, 32'h0, got);
    check_val(64'(got), 64'(exp), "register read");
  endtask : reg_chk

  task automatic fire(input logic sec);
    @(posedge ref_clk);
    if (sec) fire_second <= 1'b1;
    else fire_epoch <= 1'b1;
    @(posedge ref_clk);
    fire_second <= 1'b0;
    fire_epoch <= 1'b0;
  endtask : fire

  // 0 second, 1 sync epoch, 2 integration epoch, 3 code epoch
  task automatic wait_evt(input int which, input int limit, output int taken);
    logic hit;
    taken = 0;
    hit = 1'b0;
    while (!hit && taken < limit) begin
      @(posedge ref_clk);
      taken++;
      case (which)
        0: hit = second_pulse === 1'b1;
        1: hit = sync_epoch_pulse === 1'b1;
        2: hit = integration_epoch === 1'b1;
        default: hit = code_epoch === 1'b1;
      endcase
    end
    check_val(64'(hit), 64'h1, "event seen");
  endtask : wait_evt

  task automatic test_reset();
    check_val(64'(waitrequest), 64'h1, "idle wait");
    reg_chk(OFS_CODE_LENGTH, RST_CODE_LENGTH);
    reg_chk(OFS_INTEG_PERIOD, RST_INTEG_PERIOD);
    reg_chk(OFS_OSC_SETTINGS, RST_RATE);
    reg_chk(OFS_STATUS, 32'h0);
    reg_wr(6'h3C, 32'hFFFF_FFFF);
    reg_chk(6'h3C, 32'h0);
    $display("test reset done");
  endtask : test_reset

  // internal dividers selected after reset; outputs stand in the same cycle as the events
  task automatic test_internal();
    int taken;
    wait_evt(1, EPOCH_P + 5, taken);
    check_val(64'(epoch_sync_output), 64'h1, "epoch output");
    wait_evt(1, EPOCH_P + 5, taken);
    check_val(64'(taken), 64'(EPOCH_P), "epoch period");
    wait_evt(0, SECOND_P + 5, taken);
    check_val(64'(second_pulse_output), 64'h1, "second output");
    wait_evt(0, SECOND_P + 5, taken);
    check_val(64'(taken), 64'(SECOND_P), "second period");
    $display("test internal done");
  endtask : test_internal

  task automatic test_ext_second();
    int taken;
    int cnt;
    int cnt_int;
    cnt = 0;
    cnt_int = 0;
    reg_wr(OFS_SYNC_CONFIG, 32'h3);
    reg_chk(OFS_SYNC_CONFIG, 32'h3);
    fire(1'b1);
    wait_evt(0, 10, taken);
    check_val(64'(taken >= 3 && taken <= 8), 64'h1, "second latency");
    repeat (60) begin
      @(posedge ref_clk);
      if (second_pulse === 1'b1) cnt++;
      if (second_pulse_output === 1'b1) cnt_int++;
    end
    check_val(64'(cnt), 64'h0, "extra second events");
    check_val(64'(cnt_int > 0), 64'h1, "internal divider runs");
    $display("test external second done");
  endtask : test_ext_second

  task automatic test_time_load();
    int taken;
    reg_wr(OFS_TIME_LOW, 32'h0);
    reg_wr(OFS_TIME_HIGH, 32'h0);
    reg_chk(OFS_STATUS, 32'h1);
    check_val(64'(time_count < 64'h10), 64'h0, "early load");
    fire(1'b0);
    wait_evt(1, 10, taken);
    @(posedge ref_clk);
    check_val(time_count, 64'h0, "loaded time");
    @(posedge ref_clk);
    check_val(time_count, 64'h1, "time counts on");
    reg_chk(OFS_STATUS, 32'h2 & 32'h0);
    $display("test time load done");
  endtask : test_time_load

  task automatic test_code_start();
    int taken;
    for (int i = 0; i < 3; i++) begin
      reg_wr(OFS_CODE_GEN_CTRL, 32'h8 | (32'h1 << i));
      fire(1'b0);
      wait_evt(1, 10, taken);
      @(posedge ref_clk);
      check_val(64'(code_start), 64'(32'h1 << i), "start on sync epoch");
    end
    reg_wr(OFS_CODE_GEN_CTRL, 32'h4);
    wait_evt(2, 51000, taken);
    @(posedge ref_clk);
    check_val(64'(code_start), 64'h4, "start on integration epoch");
    reg_chk(OFS_STATUS, 32'h2);
    $display("test code start done");
  endtask : test_code_start

  task automatic test_align();
    int taken;
    int cnt_chip;
    int cnt_code;
    cnt_chip = 0;
    cnt_code = 0;
    reg_wr(OFS_CODE_LENGTH, 32'h4);
    reg_wr(OFS_OSC_SETTINGS, 32'h4000_0000);
    reg_wr(OFS_SLEW_AMOUNT, 32'h2000_0000);
    reg_chk(OFS_SLEW_AMOUNT, 32'h0);
    reg_wr(OFS_CORR_CTRL, 32'h1);
    repeat (3) begin
      wait_evt(3, 5000, taken);
      @(posedge ref_clk);
      check_val(64'(integration_epoch), 64'h1, "epoch realigned");
    end
    // quarter-turn rate: one chip every 4 cycles, four chips per code
    repeat (32) begin
      @(posedge ref_clk);
      if (chip_edge === 1'b1) cnt_chip++;
      if (code_epoch === 1'b1) cnt_code++;
    end
    check_val(64'(cnt_chip), 64'h8, "chip edges");
    check_val(64'(cnt_code), 64'h2, "code epochs");
    $display("test align done");
  endtask : test_align

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_internal();
    test_ext_second();
    test_time_load();
    test_code_start();
    test_align();
    give_verdict();
  end
endmodule : gnss_epoch_sync_code_start_tb
`default_nettype wire
